// [src/module_clock_disable_regs.vh]
// register map, field positions and reset values of the module clock disable
`ifndef MODULE_CLOCK_DISABLE_REGS_VH
`define MODULE_CLOCK_DISABLE_REGS_VH

// byte offsets on the register bus
`define MCD_DISABLE_1_OFS 12'h000
`define MCD_DISABLE_2_OFS 12'h004
`define MCD_DISABLE_3_OFS 12'h008
`define MCD_STATUS_1_OFS 12'h00c
`define MCD_STATUS_2_OFS 12'h010
`define MCD_STATUS_3_OFS 12'h014

// implemented bit positions of each disable register
`define MCD_IMPL_1 16'hfefb
`define MCD_IMPL_2 16'hc30f
`define MCD_IMPL_3 16'h07f0

// reset values
`define MCD_RESET_1 16'h0000
`define MCD_RESET_2 16'h0000
`define MCD_RESET_3 16'h0000

// first register
`define MCD_TIMER_FIVE 15
`define MCD_TIMER_FOUR 14
`define MCD_TIMER_THREE 13
`define MCD_TIMER_TWO 12
`define MCD_TIMER_ONE 11
`define MCD_ENCODER_ONE 10
`define MCD_MOTOR_PWM_ONE 9
`define MCD_TWO_WIRE_ONE 7
`define MCD_SERIAL_TWO 6
`define MCD_SERIAL_ONE 5
`define MCD_FOUR_WIRE_TWO 4
`define MCD_FOUR_WIRE_ONE 3
`define MCD_CAN_ONE 1
`define MCD_ADC_ONE 0
// second register
`define MCD_CAPTURE_EIGHT 15
`define MCD_CAPTURE_SEVEN 14
`define MCD_CAPTURE_TWO 9
`define MCD_CAPTURE_ONE 8
`define MCD_COMPARE_FOUR 3
`define MCD_COMPARE_THREE 2
`define MCD_COMPARE_TWO 1
`define MCD_COMPARE_ONE 0
// third register
`define MCD_COMPARATOR 10
`define MCD_CALENDAR 9
`define MCD_PARALLEL_MASTER 8
`define MCD_CHECKSUM 7
`define MCD_AUDIO_DAC 6
`define MCD_ENCODER_TWO 5
`define MCD_MOTOR_PWM_TWO 4

`endif

// [src/disable_word.v]
// one 16-bit disable register with unimplemented positions held at zero
`timescale 1ns/100ps
module disable_word #(
    parameter [15:0] IMPL = 16'hffff,
    parameter [15:0] RST = 16'h0000
) (
    input wire clk, // system clock
    input wire reset, // synchronous, active high
    input wire wr, // write strobe
    input wire [15:0] wdata, // write data
    output wire [15:0] q // register value
);
    reg [15:0] q_r;
    always @(posedge clk) begin
        if (reset) begin
            q_r <= RST & IMPL;
        end else if (wr) begin
            q_r <= wdata & IMPL;
        end
    end
    assign q = q_r;
endmodule

// [src/clock_gate.v]
// glitch-free clock gate, enable caught on the falling edge and held while the clock is low
`timescale 1ns/100ps
module clock_gate (
    input wire clk, // clock to gate
    input wire en, // registered enable from the clk domain
    output wire gclk // gated clock
);
    reg en_lo_r;
    // changes only on the falling edge, so a high phase is never cut short
    always @(negedge clk) begin
        en_lo_r <= en;
    end
    assign gclk = clk & en_lo_r;
endmodule

// [src/module_clock_disable.v]
// peripheral clock gating block with its APB register file
//
// Overview of operation
// - a set disable bit stops every clock going to that peripheral.
// - a disabled peripheral ignores writes to its own registers.
// - a peripheral runs only if its bit is clear and it is present.
// - every implemented disable bit resets to zero.
// - setting a bit disables the peripheral one instruction cycle later.
// - clearing a bit enables the peripheral one instruction cycle later.
// - word one bits 15..9 are timers five..one, encoder one, pwm one.
// - word one bits 7..3, 1 and 0 are two-wire, serials, four-wires, can, adc.
// - word two bits 15,14,9,8 are captures eight, seven, two and one.
// - word two bits 3..0 disable compare units four down to one.
// - word three bits 10..4 are comparator to motor pwm two.
// - unimplemented disable bits read as zero.
`timescale 1ns/100ps
`include "module_clock_disable_regs.vh"
module module_clock_disable #(
    parameter [15:0] PRESENT_1 = 16'hfefb, // peripherals in this variant
    parameter [15:0] PRESENT_2 = 16'hc30f,
    parameter [15:0] PRESENT_3 = 16'h07f0
) (
    input wire CLK, // system clock, 20 MHz
    input wire RESET, // synchronous reset, active high
    input wire PSEL, // apb select
    input wire PENABLE, // apb access phase
    input wire PWRITE, // apb direction, high for write
    input wire [11:0] PADDR, // apb byte address
    input wire [31:0] PWDATA, // apb write data
    output wire PREADY, // apb ready
    output wire [31:0] PRDATA, // apb read data
    output wire PSLVERR, // apb error on unmapped address
    input wire [15:0] PERIPH_WR_1, // peripheral register writes, word one
    input wire [15:0] PERIPH_WR_2, // peripheral register writes, word two
    input wire [15:0] PERIPH_WR_3, // peripheral register writes, word three
    output wire [15:0] PERIPH_WR_OK_1, // writes passed on, word one
    output wire [15:0] PERIPH_WR_OK_2, // writes passed on, word two
    output wire [15:0] PERIPH_WR_OK_3, // writes passed on, word three
    output wire [15:0] ACCESS_EN_1, // register access enables, word one
    output wire [15:0] ACCESS_EN_2, // register access enables, word two
    output wire [15:0] ACCESS_EN_3, // register access enables, word three
    output wire TIMER_FIVE_CLK, // gated clocks, one per peripheral
    output wire TIMER_FOUR_CLK, // timer four
    output wire TIMER_THREE_CLK, // timer three
    output wire TIMER_TWO_CLK, // timer two
    output wire TIMER_ONE_CLK, // timer one
    output wire ENCODER_ONE_CLK, // quadrature encoder one
    output wire MOTOR_PWM_ONE_CLK, // motor pwm one
    output wire TWO_WIRE_ONE_CLK, // i2c one
    output wire SERIAL_PORT_TWO_CLK, // uart two
    output wire SERIAL_PORT_ONE_CLK, // uart one
    output wire FOUR_WIRE_TWO_CLK, // spi two
    output wire FOUR_WIRE_ONE_CLK, // spi one
    output wire CAN_ONE_CLK, // can one
    output wire ADC_ONE_CLK, // adc one
    output wire CAPTURE_EIGHT_CLK, // input capture eight
    output wire CAPTURE_SEVEN_CLK, // input capture seven
    output wire CAPTURE_TWO_CLK, // input capture two
    output wire CAPTURE_ONE_CLK, // input capture one
    output wire COMPARE_FOUR_CLK, // output compare four
    output wire COMPARE_THREE_CLK, // output compare three
    output wire COMPARE_TWO_CLK, // output compare two
    output wire COMPARE_ONE_CLK, // output compare one
    output wire COMPARATOR_CLK, // analog comparator
    output wire CALENDAR_CLOCK_CLK, // real-time clock
    output wire PARALLEL_MASTER_CLK, // parallel master port
    output wire CHECKSUM_UNIT_CLK, // crc
    output wire AUDIO_DAC_CLK, // audio dac
    output wire ENCODER_TWO_CLK, // quadrature encoder two
    output wire MOTOR_PWM_TWO_CLK // motor pwm two
);

    // effective enable: bit clear, position implemented, peripheral present
    function [15:0] run_mask;
        input [15:0] dis;
        input [15:0] impl;
        input [15:0] present;
        begin
            run_mask = ~dis & impl & present;
        end
    endfunction

    // register index from byte address, 3'h7 when unmapped
    function [2:0] reg_index;
        input [11:0] addr;
        begin
            case (addr)
                `MCD_DISABLE_1_OFS: reg_index = 3'h0;
                `MCD_DISABLE_2_OFS: reg_index = 3'h1;
                `MCD_DISABLE_3_OFS: reg_index = 3'h2;
                `MCD_STATUS_1_OFS: reg_index = 3'h3;
                `MCD_STATUS_2_OFS: reg_index = 3'h4;
                `MCD_STATUS_3_OFS: reg_index = 3'h5;
                default: reg_index = 3'h7;
            endcase
        end
    endfunction

    wire setup_ph;
    wire access_ph;
    wire [2:0] sel_idx;
    wire wr_acc;
    wire [15:0] dis_1;
    wire [15:0] dis_2;
    wire [15:0] dis_3;
    reg [15:0] run_1_r;
    reg [15:0] run_2_r;
    reg [15:0] run_3_r;
    reg [15:0] rd_nxt;
    reg [31:0] prdata_r;
    reg pslverr_r;
    reg err_nxt;

    // zero wait states: read data is caught in the setup cycle
    assign setup_ph = PSEL & ~PENABLE;
    assign access_ph = PSEL & PENABLE;
    assign sel_idx = reg_index(PADDR);
    assign wr_acc = access_ph & PWRITE;
    assign PREADY = 1'b1;
    assign PRDATA = prdata_r;
    assign PSLVERR = pslverr_r;

    disable_word #(
        .IMPL(`MCD_IMPL_1),
        .RST(`MCD_RESET_1)
    ) word_one (
        .clk(CLK),
        .reset(RESET),
        .wr(wr_acc & (sel_idx == 3'h0)),
        .wdata(PWDATA[15:0]),
        .q(dis_1)
    );

    disable_word #(
        .IMPL(`MCD_IMPL_2),
        .RST(`MCD_RESET_2)
    ) word_two (
        .clk(CLK),
        .reset(RESET),
        .wr(wr_acc & (sel_idx == 3'h1)),
        .wdata(PWDATA[15:0]),
        .q(dis_2)
    );

    disable_word #(
        .IMPL(`MCD_IMPL_3),
        .RST(`MCD_RESET_3)
    ) word_three (
        .clk(CLK),
        .reset(RESET),
        .wr(wr_acc & (sel_idx == 3'h2)),
        .wdata(PWDATA[15:0]),
        .q(dis_3)
    );

    // read mux; status words show what the peripherals really see
    always @* begin
        rd_nxt = 16'h0000;
        err_nxt = 1'b0;
        case (sel_idx)
            3'h0: rd_nxt = dis_1;
            3'h1: rd_nxt = dis_2;
            3'h2: rd_nxt = dis_3;
            3'h3: rd_nxt = run_1_r;
            3'h4: rd_nxt = run_2_r;
            3'h5: rd_nxt = run_3_r;
            default: err_nxt = 1'b1;
        endcase
    end

    always @(posedge CLK) begin
        if (RESET) begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (setup_ph) begin
            prdata_r <= PWRITE ? 32'h00000000 : {16'h0000, rd_nxt};
            pslverr_r <= err_nxt;
        end else begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end
    end

    // one cycle behind the disable word, in either direction
    always @(posedge CLK) begin
        if (RESET) begin
            run_1_r <= `MCD_IMPL_1 & PRESENT_1;
            run_2_r <= `MCD_IMPL_2 & PRESENT_2;
            run_3_r <= `MCD_IMPL_3 & PRESENT_3;
        end else begin
            run_1_r <= run_mask(dis_1, `MCD_IMPL_1, PRESENT_1);
            run_2_r <= run_mask(dis_2, `MCD_IMPL_2, PRESENT_2);
            run_3_r <= run_mask(dis_3, `MCD_IMPL_3, PRESENT_3);
        end
    end

    assign ACCESS_EN_1 = run_1_r;
    assign ACCESS_EN_2 = run_2_r;
    assign ACCESS_EN_3 = run_3_r;

    // a disabled peripheral's register writes never reach it
    assign PERIPH_WR_OK_1 = PERIPH_WR_1 & run_1_r;
    assign PERIPH_WR_OK_2 = PERIPH_WR_2 & run_2_r;
    assign PERIPH_WR_OK_3 = PERIPH_WR_3 & run_3_r;

    // a gate at every implemented position, present or not; an absent peripheral's clock stays low
    // word one, upper byte
    clock_gate timer_five_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_TIMER_FIVE]),
        .gclk(TIMER_FIVE_CLK)
    );
    clock_gate timer_four_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_TIMER_FOUR]),
        .gclk(TIMER_FOUR_CLK)
    );
    clock_gate timer_three_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_TIMER_THREE]),
        .gclk(TIMER_THREE_CLK)
    );
    clock_gate timer_two_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_TIMER_TWO]),
        .gclk(TIMER_TWO_CLK)
    );
    clock_gate timer_one_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_TIMER_ONE]),
        .gclk(TIMER_ONE_CLK)
    );
    clock_gate encoder_one_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_ENCODER_ONE]),
        .gclk(ENCODER_ONE_CLK)
    );
    clock_gate motor_pwm_one_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_MOTOR_PWM_ONE]),
        .gclk(MOTOR_PWM_ONE_CLK)
    );

    // word one, lower byte
    clock_gate two_wire_one_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_TWO_WIRE_ONE]),
        .gclk(TWO_WIRE_ONE_CLK)
    );
    clock_gate serial_two_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_SERIAL_TWO]),
        .gclk(SERIAL_PORT_TWO_CLK)
    );
    clock_gate serial_one_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_SERIAL_ONE]),
        .gclk(SERIAL_PORT_ONE_CLK)
    );
    clock_gate four_wire_two_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_FOUR_WIRE_TWO]),
        .gclk(FOUR_WIRE_TWO_CLK)
    );
    clock_gate four_wire_one_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_FOUR_WIRE_ONE]),
        .gclk(FOUR_WIRE_ONE_CLK)
    );
    clock_gate can_one_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_CAN_ONE]),
        .gclk(CAN_ONE_CLK)
    );
    clock_gate adc_one_gate (
        .clk(CLK),
        .en(run_1_r[`MCD_ADC_ONE]),
        .gclk(ADC_ONE_CLK)
    );

    // word two
    clock_gate capture_eight_gate (
        .clk(CLK),
        .en(run_2_r[`MCD_CAPTURE_EIGHT]),
        .gclk(CAPTURE_EIGHT_CLK)
    );
    clock_gate capture_seven_gate (
        .clk(CLK),
        .en(run_2_r[`MCD_CAPTURE_SEVEN]),
        .gclk(CAPTURE_SEVEN_CLK)
    );
    clock_gate capture_two_gate (
        .clk(CLK),
        .en(run_2_r[`MCD_CAPTURE_TWO]),
        .gclk(CAPTURE_TWO_CLK)
    );
    clock_gate capture_one_gate (
        .clk(CLK),
        .en(run_2_r[`MCD_CAPTURE_ONE]),
        .gclk(CAPTURE_ONE_CLK)
    );
    clock_gate compare_four_gate (
        .clk(CLK),
        .en(run_2_r[`MCD_COMPARE_FOUR]),
        .gclk(COMPARE_FOUR_CLK)
    );
    clock_gate compare_three_gate (
        .clk(CLK),
        .en(run_2_r[`MCD_COMPARE_THREE]),
        .gclk(COMPARE_THREE_CLK)
    );
    clock_gate compare_two_gate (
        .clk(CLK),
        .en(run_2_r[`MCD_COMPARE_TWO]),
        .gclk(COMPARE_TWO_CLK)
    );
    clock_gate compare_one_gate (
        .clk(CLK),
        .en(run_2_r[`MCD_COMPARE_ONE]),
        .gclk(COMPARE_ONE_CLK)
    );

    // word three
    clock_gate comparator_gate (
        .clk(CLK),
        .en(run_3_r[`MCD_COMPARATOR]),
        .gclk(COMPARATOR_CLK)
    );
    clock_gate calendar_gate (
        .clk(CLK),
        .en(run_3_r[`MCD_CALENDAR]),
        .gclk(CALENDAR_CLOCK_CLK)
    );
    clock_gate parallel_master_gate (
        .clk(CLK),
        .en(run_3_r[`MCD_PARALLEL_MASTER]),
        .gclk(PARALLEL_MASTER_CLK)
    );
    clock_gate checksum_gate (
        .clk(CLK),
        .en(run_3_r[`MCD_CHECKSUM]),
        .gclk(CHECKSUM_UNIT_CLK)
    );
    clock_gate audio_dac_gate (
        .clk(CLK),
        .en(run_3_r[`MCD_AUDIO_DAC]),
        .gclk(AUDIO_DAC_CLK)
    );
    clock_gate encoder_two_gate (
        .clk(CLK),
        .en(run_3_r[`MCD_ENCODER_TWO]),
        .gclk(ENCODER_TWO_CLK)
    );
    clock_gate motor_pwm_two_gate (
        .clk(CLK),
        .en(run_3_r[`MCD_MOTOR_PWM_TWO]),
        .gclk(MOTOR_PWM_TWO_CLK)
    );

endmodule

// [verif/mcd_props_props.sv]
// assertions on the ports of the module clock disable block
`timescale 1ns/100ps
`include "module_clock_disable_regs.vh"
module mcd_props #(
    parameter [15:0] PRESENT_1 = 16'hfefb,
    parameter [15:0] PRESENT_3 = 16'h07f0
) (
    input wire CLK, // clock
    input wire RESET, // sync reset
    input wire PSEL, // apb
    input wire PENABLE, // apb
    input wire PWRITE, // apb
    input wire [11:0] PADDR, // apb
    input wire [31:0] PWDATA, // apb
    input wire PREADY, // apb
    input wire [31:0] PRDATA, // apb
    input wire PSLVERR, // apb
    input wire [15:0] PERIPH_WR_2, // strobes in
    input wire [15:0] PERIPH_WR_OK_2, // strobes out
    input wire [15:0] ACCESS_EN_1, // enables
    input wire [15:0] ACCESS_EN_2, // enables
    input wire [15:0] ACCESS_EN_3, // enables
    input wire TIMER_FIVE_CLK // gated clock
);
    wire acc = PSEL && PENABLE;
    wire [15:0] wlo = PWDATA[15:0];
    wire t5_en = ACCESS_EN_1[15];
    ready_high_a: assert property (@(posedge CLK) disable iff (RESET)
        PREADY) else $error("pready low");
    rd_idle_a: assert property (@(posedge CLK) disable iff (RESET)
        !acc |-> PRDATA == 32'h0) else $error("read data not zero");
    reset_en_a: assert property (@(posedge CLK)
        RESET [*2] |-> ACCESS_EN_1 == (`MCD_IMPL_1 & PRESENT_1))
        else $error("enables wrong after reset");
    lat_one_a: assert property (@(posedge CLK) disable iff (RESET)
        acc && PWRITE && PADDR == `MCD_DISABLE_1_OFS |=> $stable(ACCESS_EN_1)
        ##1 ACCESS_EN_1 == (~$past(wlo, 2) & `MCD_IMPL_1 & PRESENT_1))
        else $error("word one enable timing");
    lat_three_a: assert property (@(posedge CLK) disable iff (RESET)
        acc && PWRITE && PADDR == `MCD_DISABLE_3_OFS |-> ##2
        ACCESS_EN_3 == (~$past(wlo, 2) & `MCD_IMPL_3 & PRESENT_3))
        else $error("word three enable timing");
    wr_gate_a: assert property (@(posedge CLK) disable iff (RESET)
        PERIPH_WR_OK_2 == (PERIPH_WR_2 & ACCESS_EN_2))
        else $error("strobe passed while disabled");
    absent_off_a: assert property (@(posedge CLK) disable iff (RESET)
        (ACCESS_EN_3 & ~PRESENT_3) == 16'h0) else $error("absent unit on");
    unimpl_zero_a: assert property (@(posedge CLK) disable iff (RESET)
        acc && !PWRITE && PADDR == `MCD_DISABLE_2_OFS |->
        (PRDATA & ~{16'h0, `MCD_IMPL_2}) == 32'h0)
        else $error("unimplemented bits read high");
    unmapped_err_a: assert property (@(posedge CLK) disable iff (RESET)
        acc |-> PSLVERR == (PADDR > `MCD_STATUS_3_OFS ||
        PADDR[1:0] != 2'h0))
        else $error("slave error wrong");
    gate_clk_a: assert property (@(negedge CLK) disable iff (RESET)
        TIMER_FIVE_CLK == $past(t5_en)) else $error("timer five clock wrong");
endmodule

// [verif/testbench.sv]
// self-checking bench for the module clock disable block
`timescale 1ns/100ps
`include "module_clock_disable_regs.vh"
module testbench;
    localparam [15:0] PRES3 = 16'h07b0; // audio dac absent in this variant
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwr = 1'b0;
    reg [11:0] paddr = 12'h0;
    reg [31:0] pwdata = 32'h0;
    reg [15:0] pw [0:2];
    wire [15:0] ok [0:2];
    wire [15:0] en [0:2];
    wire pready;
    wire pslverr;
    wire [31:0] prdata;
    wire [28:0] gck;
    integer miscompares = 0;
    integer check_count = 0;
    integer cyc = 0;
    integer seed = 32'h1f3a01ea;
    integer i, k;
    reg [15:0] dis [0:2];
    reg [15:0] impl [0:2];
    reg [15:0] pres [0:2];
    reg [15:0] ee [0:2];
    reg [31:0] r;
    reg [31:0] d;
    reg [31:0] rd_d;
    reg rd_e;
    module_clock_disable #(.PRESENT_3(PRES3)) u_dut (
        .CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwr),
        .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .PERIPH_WR_1(pw[0]), .PERIPH_WR_2(pw[1]),
        .PERIPH_WR_3(pw[2]), .PERIPH_WR_OK_1(ok[0]), .PERIPH_WR_OK_2(ok[1]),
        .PERIPH_WR_OK_3(ok[2]), .ACCESS_EN_1(en[0]), .ACCESS_EN_2(en[1]),
        .ACCESS_EN_3(en[2]), .TIMER_FIVE_CLK(gck[13]),
        .TIMER_FOUR_CLK(gck[12]), .TIMER_THREE_CLK(gck[11]),
        .TIMER_TWO_CLK(gck[10]), .TIMER_ONE_CLK(gck[9]),
        .ENCODER_ONE_CLK(gck[8]), .MOTOR_PWM_ONE_CLK(gck[7]),
        .TWO_WIRE_ONE_CLK(gck[6]), .SERIAL_PORT_TWO_CLK(gck[5]),
        .SERIAL_PORT_ONE_CLK(gck[4]), .FOUR_WIRE_TWO_CLK(gck[3]),
        .FOUR_WIRE_ONE_CLK(gck[2]), .CAN_ONE_CLK(gck[1]),
        .ADC_ONE_CLK(gck[0]), .CAPTURE_EIGHT_CLK(gck[21]),
        .CAPTURE_SEVEN_CLK(gck[20]), .CAPTURE_TWO_CLK(gck[19]),
        .CAPTURE_ONE_CLK(gck[18]), .COMPARE_FOUR_CLK(gck[17]),
        .COMPARE_THREE_CLK(gck[16]), .COMPARE_TWO_CLK(gck[15]),
        .COMPARE_ONE_CLK(gck[14]), .COMPARATOR_CLK(gck[28]),
        .CALENDAR_CLOCK_CLK(gck[27]), .PARALLEL_MASTER_CLK(gck[26]),
        .CHECKSUM_UNIT_CLK(gck[25]), .AUDIO_DAC_CLK(gck[24]),
        .ENCODER_TWO_CLK(gck[23]), .MOTOR_PWM_TWO_CLK(gck[22]));
    always #25 clk = ~clk;
    task end_sim;
        begin
            $display("checks %0d miscompares %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            end_sim;
        end
    end
    task chk(input string nm, input [31:0] exp, input [31:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // request held until pready is seen high, answer taken in that cycle
    task apb(input w, input [11:0] a, input [31:0] dat);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwr <= w;
            paddr <= a;
            pwdata <= dat;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1)
                @(posedge clk);
            rd_d = prdata;
            rd_e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task outs;
        begin
            @(posedge clk);
            for (i = 0; i < 3; i = i + 1) begin
                r = $random(seed);
                pw[i] <= r[15:0];
            end
            @(posedge clk);
            #1;
            for (i = 0; i < 3; i = i + 1)
                ee[i] = ~dis[i] & impl[i] & pres[i];
            // clock is high here, so each gated clock shows its enable
            r = {3'h0, ee[2][10:4], ee[1][15:14], ee[1][9:8], ee[1][3:0],
                ee[0][15:9], ee[0][7:3], ee[0][1:0]};
            chk("gated clocks", r, {3'h0, gck});
            for (i = 0; i < 3; i = i + 1) begin
                chk("enable", {16'h0, ee[i]}, {16'h0, en[i]});
                chk("strobe", {16'h0, pw[i] & ee[i]}, {16'h0, ok[i]});
                apb(1'b0, 12'(i * 4), 32'h0);
                chk("disable word", {16'h0, dis[i]}, rd_d);
                apb(1'b0, 12'(i * 4 + 12), 32'h0);
                chk("status word", {16'h0, ee[i]}, rd_d);
            end
        end
    endtask
    initial begin
        impl[0] = `MCD_IMPL_1;
        impl[1] = `MCD_IMPL_2;
        impl[2] = `MCD_IMPL_3;
        pres[0] = `MCD_IMPL_1;
        pres[1] = `MCD_IMPL_2;
        pres[2] = PRES3;
        for (i = 0; i < 3; i = i + 1) begin
            dis[i] = 16'h0;
            pw[i] = 16'h0;
        end
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        outs;
        for (k = 0; k < 15; k = k + 1) begin
            d = k < 3 ? 32'hffffffff : (k < 6 ? 32'h0 : $random(seed));
            apb(1'b1, 12'((k % 3) * 4), d);
            dis[k % 3] = d[15:0] & impl[k % 3];
            outs;
        end
        // refused accesses leave the enables untouched
        apb(1'b1, `MCD_STATUS_1_OFS, 32'hffff);
        chk("status write error", 32'h0, {31'h0, rd_e});
        apb(1'b1, 12'h018, 32'hffff);
        chk("unmapped write error", 32'h1, {31'h0, rd_e});
        apb(1'b0, 12'h7fc, 32'h0);
        chk("unmapped read error", 32'h1, {31'h0, rd_e});
        chk("unmapped read data", 32'h0, rd_d);
        outs;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 3; i = i + 1)
            dis[i] = 16'h0;
        outs;
        end_sim;
    end
endmodule
bind module_clock_disable mcd_props #(.PRESENT_1(PRESENT_1),
    .PRESENT_3(PRESENT_3)) u_props (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE,
    .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR, .PERIPH_WR_2,
    .PERIPH_WR_OK_2, .ACCESS_EN_1, .ACCESS_EN_2, .ACCESS_EN_3,
    .TIMER_FIVE_CLK);
